/* abs_diff_sum.sv */
/*
  combinational byte-wise sum of absolute differences with optional
  accumulation.
  assumes the caller registers the result; the total wraps at 32 bits.
*/
`timescale 1ns/10ps
module abs_diff_sum (
  // operands
  input  wire simd_pkg::word_t a,
  input  wire simd_pkg::word_t b,
  input  wire simd_pkg::word_t acc,
  input  wire logic            acc_en,
  // result
  output simd_pkg::word_t      total
);

  always_comb begin
    total = acc_en ? acc : simd_pkg::WORD_RST;
    for (int i = 0; i < simd_pkg::BYTE_LNS; i++) begin
      total = simd_pkg::word_t'(total +
        simd_pkg::word_t'(simd_pkg::abs_diff8(simd_pkg::byte_of(a, i),
                                              simd_pkg::byte_of(b, i))));
    end
  end

endmodule

/* lane_arith.sv */
/*
  combinational lane adder/subtractor for the exchange, halving and plain
  lane subtract operations.
  assumes the caller registers the result.
*/
`timescale 1ns/10ps
module lane_arith (
  // operation
  input  wire simd_pkg::op_e  op,
  // operands
  input  wire simd_pkg::word_t a,
  input  wire simd_pkg::word_t b,
  // result
  output simd_pkg::word_t      res
);

  always_comb begin
    res = simd_pkg::WORD_RST;
    case (op)
      simd_pkg::OP_HALVING_ADD_SUB_SWAP: begin
        res = {simd_pkg::halve_add16(simd_pkg::hi_half(a), simd_pkg::lo_half(b)),
               simd_pkg::halve_sub16(simd_pkg::lo_half(a), simd_pkg::hi_half(b))};
      end
      simd_pkg::OP_HALVING_SUB_ADD_SWAP: begin
        res = {simd_pkg::halve_sub16(simd_pkg::hi_half(a), simd_pkg::lo_half(b)),
               simd_pkg::halve_add16(simd_pkg::lo_half(a), simd_pkg::hi_half(b))};
      end
      simd_pkg::OP_HALVING_SUB_HALFWORDS: begin
        res = {simd_pkg::halve_sub16(simd_pkg::hi_half(a), simd_pkg::hi_half(b)),
               simd_pkg::halve_sub16(simd_pkg::lo_half(a), simd_pkg::lo_half(b))};
      end
      simd_pkg::OP_HALVING_SUB_BYTES: begin
        for (int i = 0; i < simd_pkg::BYTE_LNS; i++) begin
          res[i*simd_pkg::BYTE_W +: simd_pkg::BYTE_W] =
            simd_pkg::halve_sub8(simd_pkg::byte_of(a, i), simd_pkg::byte_of(b, i));
        end
      end
      simd_pkg::OP_SUB_HALFWORDS: begin
        res = {simd_pkg::half_t'(simd_pkg::hi_half(a) - simd_pkg::hi_half(b)),
               simd_pkg::half_t'(simd_pkg::lo_half(a) - simd_pkg::lo_half(b))};
      end
      simd_pkg::OP_SUB_BYTES: begin
        for (int i = 0; i < simd_pkg::BYTE_LNS; i++) begin
          res[i*simd_pkg::BYTE_W +: simd_pkg::BYTE_W] =
            simd_pkg::byte_t'(simd_pkg::byte_of(a, i) - simd_pkg::byte_of(b, i));
        end
      end
      default: begin
        res = simd_pkg::WORD_RST;
      end
    endcase
  end

endmodule

/* regfile_model.sv */
/*
  register file model standing beside the lane unit: three read ports feed
  the operands, the unit's result is written back, the bench can preload.
  assumes the bench only preloads while no result is being written back.
*/
`timescale 1ns/10ps
module regfile_model (
  // clock
  input  wire logic            clk,
  // operand reads
  input  wire simd_pkg::idx_t  rd_a_idx,
  input  wire simd_pkg::idx_t  rd_b_idx,
  input  wire simd_pkg::idx_t  rd_c_idx,
  output simd_pkg::word_t      rd_a,
  output simd_pkg::word_t      rd_b,
  output simd_pkg::word_t      rd_c,
  // write back from the unit
  input  wire logic            wb_valid,
  input  wire simd_pkg::idx_t  wb_idx,
  input  wire simd_pkg::word_t wb_data,
  // preload from the bench
  input  wire logic            ld_en,
  input  wire simd_pkg::idx_t  ld_idx,
  input  wire simd_pkg::word_t ld_val
);
  simd_pkg::word_t mem [16];

  // no forwarding: a read in the write-back cycle sees the old value
  assign rd_a = mem[rd_a_idx];
  assign rd_b = mem[rd_b_idx];
  assign rd_c = mem[rd_c_idx];

  always_ff @(posedge clk) begin
    if (wb_valid) begin
      mem[wb_idx] <= wb_data;
    end else if (ld_en) begin
      mem[ld_idx] <= ld_val;
    end
  end
endmodule

/* simd_pkg.sv */
/*
  shared constants, types and lane helpers for the packed unsigned lane unit.
  assumes 32-bit register operands and a 4-bit register index space.
*/
package simd_pkg;

  // --------------------------------------------------------------
  // widths and register indices
  // --------------------------------------------------------------
  localparam int WORD_W    = 32;
  localparam int HALF_W    = 16;
  localparam int BYTE_W    = 8;
  localparam int BYTE_LNS  = 4;
  localparam int IDX_W     = 4;
  localparam int FLAG_W    = 4;

  typedef logic [WORD_W-1:0]   word_t;
  typedef logic [HALF_W-1:0]   half_t;
  typedef logic [BYTE_W-1:0]   byte_t;
  typedef logic [IDX_W-1:0]    idx_t;
  typedef logic [FLAG_W-1:0]   flags_t;

  localparam idx_t  STACK_POINTER_IDX   = 4'hD;
  localparam idx_t  PROGRAM_COUNTER_IDX = 4'hF;
  localparam word_t WORD_RST            = 32'h0000_0000;
  localparam idx_t  IDX_RST             = 4'h0;

  // --------------------------------------------------------------
  // operation codes
  // --------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_HALVING_ADD_SUB_SWAP  = 4'h0,
    OP_HALVING_SUB_ADD_SWAP  = 4'h1,
    OP_HALVING_SUB_HALFWORDS = 4'h2,
    OP_HALVING_SUB_BYTES     = 4'h3,
    OP_BYTE_ABS_DIFF_SUM     = 4'h4,
    OP_BYTE_ABS_DIFF_SUM_ACC = 4'h5,
    OP_SUB_HALFWORDS         = 4'h6,
    OP_SUB_BYTES             = 4'h7,
    OP_SELECT_BYTES          = 4'h8
  } op_e;

  // --------------------------------------------------------------
  // lane helpers
  // --------------------------------------------------------------
  function automatic half_t hi_half(input word_t w);
    return w[HALF_W +: HALF_W];
  endfunction

  function automatic half_t lo_half(input word_t w);
    return w[0 +: HALF_W];
  endfunction

  function automatic byte_t byte_of(input word_t w, input int i);
    return w[i*BYTE_W +: BYTE_W];
  endfunction

  // one guard bit keeps the carry before the halving shift
  function automatic half_t halve_add16(input half_t a, input half_t b);
    logic [HALF_W:0] t;
    t = {1'b0, a} + {1'b0, b};
    return t[HALF_W:1];
  endfunction

  // guard bit holds the borrow, so a negative difference halves exactly
  function automatic half_t halve_sub16(input half_t a, input half_t b);
    logic [HALF_W:0] t;
    t = {1'b0, a} - {1'b0, b};
    return t[HALF_W:1];
  endfunction

  function automatic byte_t halve_sub8(input byte_t a, input byte_t b);
    logic [BYTE_W:0] t;
    t = {1'b0, a} - {1'b0, b};
    return t[BYTE_W:1];
  endfunction

  function automatic byte_t abs_diff8(input byte_t a, input byte_t b);
    return (a >= b) ? byte_t'(a - b) : byte_t'(b - a);
  endfunction

  function automatic word_t sel_bytes(input flags_t f, input word_t a, input word_t b);
    word_t r;
    r = WORD_RST;
    for (int i = 0; i < BYTE_LNS; i++) begin
      r[i*BYTE_W +: BYTE_W] = f[i] ? byte_of(a, i) : byte_of(b, i);
    end
    return r;
  endfunction

endpackage

/* simd_unsigned_halving_sad_unit.sv */
/*
  packed unsigned lane execution slice: halving exchange ops, halving and
  plain lane subtracts, byte sum of absolute differences and byte select.
  assumes the decoder presents one operation per cycle with its operands
  already read from the register file; the result returns one cycle later.
*/
// Summary of operation
// - swap add: first hi plus second lo, halved
// - swap add: first lo minus second hi, halved
// - swap sub: first hi minus second lo, halved
// - swap sub: first lo plus second hi, halved
// - halving shifts each lane right one bit
// - exchange ops leave status flags untouched
// - halving halfword subtract, each lane unsigned
// - halving byte subtract, four lanes, shifted
// - subtract, select, sums never write flags
// - select takes each byte from same lane
// - select reads all four compare flags
// - sum of four byte absolute differences
// - accumulating sum adds accumulator register value
// - plain halfword subtract, no halving
// - plain byte subtract, unsigned bytes
// - missing destination means first source register
`timescale 1ns/10ps
module simd_unsigned_halving_sad_unit (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // request from the decoder
  input  wire logic            op_valid,
  input  wire simd_pkg::op_e   op_code,
  input  wire simd_pkg::word_t first_source,
  input  wire simd_pkg::word_t second_source,
  input  wire simd_pkg::word_t accumulator_source,
  input  wire simd_pkg::idx_t  first_index,
  input  wire simd_pkg::idx_t  second_index,
  input  wire simd_pkg::idx_t  dest_index,
  input  wire logic            dest_given,
  // program status word
  input  wire simd_pkg::flags_t per_byte_compare_flags,
  // result to the register file
  output simd_pkg::word_t      result_r,
  output simd_pkg::idx_t       result_dest_r,
  output logic                 result_valid_r,
  output logic                 flags_write_r,
  output logic                 reg_fault_r
);

  // --------------------------------------------------------------
  // reset release
  // --------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic       rst_int_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_int_n = rst_sync_r[1];

  // --------------------------------------------------------------
  // datapath
  // --------------------------------------------------------------
  simd_pkg::word_t lane_res;
  simd_pkg::word_t sad_res;
  simd_pkg::word_t result_nxt;
  simd_pkg::idx_t  result_dest_nxt;
  logic            taken;
  logic            fault_nxt;

  assign taken = op_valid && rst_int_n;

  lane_arith u_lane_arith (
    .op  (op_code),
    .a   (first_source),
    .b   (second_source),
    .res (lane_res)
  );

  abs_diff_sum u_abs_diff_sum (
    .a      (first_source),
    .b      (second_source),
    .acc    (accumulator_source),
    .acc_en (op_code == simd_pkg::OP_BYTE_ABS_DIFF_SUM_ACC),
    .total  (sad_res)
  );

  always_comb begin
    result_nxt = lane_res;
    case (op_code)
      simd_pkg::OP_BYTE_ABS_DIFF_SUM: begin
        result_nxt = sad_res;
      end
      simd_pkg::OP_BYTE_ABS_DIFF_SUM_ACC: begin
        result_nxt = sad_res;
      end
      simd_pkg::OP_SELECT_BYTES: begin
        result_nxt = simd_pkg::sel_bytes(per_byte_compare_flags,
                                         first_source, second_source);
      end
      default: begin
        result_nxt = lane_res;
      end
    endcase
  end

  // destination falls back to the first source register
  assign result_dest_nxt = dest_given ? dest_index : first_index;

  // a named stack or program counter is reported, not corrected; select is exempt
  always_comb begin
    fault_nxt = 1'b0;
    if (op_code != simd_pkg::OP_SELECT_BYTES) begin
      fault_nxt = (first_index == simd_pkg::STACK_POINTER_IDX) ||
                  (first_index == simd_pkg::PROGRAM_COUNTER_IDX) ||
                  (second_index == simd_pkg::STACK_POINTER_IDX) ||
                  (second_index == simd_pkg::PROGRAM_COUNTER_IDX) ||
                  (result_dest_nxt == simd_pkg::STACK_POINTER_IDX) ||
                  (result_dest_nxt == simd_pkg::PROGRAM_COUNTER_IDX);
    end
  end

  // --------------------------------------------------------------
  // result registers
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      result_valid_r <= 1'b0;
    end else begin
      result_valid_r <= op_valid;
    end
  end

  // result holds its last value between operations
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      result_r <= simd_pkg::WORD_RST;
    end else if (op_valid) begin
      result_r <= result_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      result_dest_r <= simd_pkg::IDX_RST;
    end else if (op_valid) begin
      result_dest_r <= result_dest_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      reg_fault_r <= 1'b0;
    end else begin
      reg_fault_r <= op_valid && fault_nxt;
    end
  end

  // no operation of this slice ever updates the status flags
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      flags_write_r <= 1'b0;
    end else begin
      flags_write_r <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_int_n);

  AST_SWAP_ADD_HI: assert property (
    taken && op_code == simd_pkg::OP_HALVING_ADD_SUB_SWAP |=>
      result_valid_r && simd_pkg::hi_half(result_r) ==
      simd_pkg::half_t'(({1'b0, simd_pkg::hi_half($past(first_source))} +
                          {1'b0, simd_pkg::lo_half($past(second_source))}) >> 1))
    else $error("swap add upper lane wrong");

  AST_SWAP_ADD_LO: assert property (
    taken && op_code == simd_pkg::OP_HALVING_ADD_SUB_SWAP |=>
      simd_pkg::lo_half(result_r) ==
      simd_pkg::half_t'(({1'b0, simd_pkg::lo_half($past(first_source))} -
                          {1'b0, simd_pkg::hi_half($past(second_source))}) >> 1))
    else $error("swap add lower lane wrong");

  AST_SWAP_SUB_HI: assert property (
    taken && op_code == simd_pkg::OP_HALVING_SUB_ADD_SWAP |=>
      simd_pkg::hi_half(result_r) ==
      simd_pkg::half_t'(({1'b0, simd_pkg::hi_half($past(first_source))} -
                          {1'b0, simd_pkg::lo_half($past(second_source))}) >> 1))
    else $error("swap sub upper lane wrong");

  AST_SWAP_SUB_LO: assert property (
    taken && op_code == simd_pkg::OP_HALVING_SUB_ADD_SWAP |=>
      simd_pkg::lo_half(result_r) ==
      simd_pkg::half_t'(({1'b0, simd_pkg::lo_half($past(first_source))} +
                          {1'b0, simd_pkg::hi_half($past(second_source))}) >> 1))
    else $error("swap sub lower lane wrong");

  AST_HALVE_TOP_BIT: assert property (
    taken && op_code == simd_pkg::OP_HALVING_ADD_SUB_SWAP &&
    simd_pkg::hi_half(first_source) == simd_pkg::lo_half(second_source) |=>
      simd_pkg::hi_half(result_r) == simd_pkg::hi_half($past(first_source)))
    else $error("halving of equal addends does not return the addend");

  AST_NO_FLAG_WRITE: assert property (
    taken ##1 result_valid_r |-> !flags_write_r ##1 !flags_write_r)
    else $error("status flags written by lane unit");

  AST_HSUB16: assert property (
    taken && op_code == simd_pkg::OP_HALVING_SUB_HALFWORDS |=>
      result_r == {simd_pkg::halve_sub16(simd_pkg::hi_half($past(first_source)),
                                         simd_pkg::hi_half($past(second_source))),
                   simd_pkg::halve_sub16(simd_pkg::lo_half($past(first_source)),
                                         simd_pkg::lo_half($past(second_source)))})
    else $error("halving halfword subtract wrong");

  AST_HSUB8_LANE0: assert property (
    taken && op_code == simd_pkg::OP_HALVING_SUB_BYTES |=>
      simd_pkg::byte_of(result_r, 0) ==
      simd_pkg::byte_t'(({1'b0, simd_pkg::byte_of($past(first_source), 0)} -
                          {1'b0, simd_pkg::byte_of($past(second_source), 0)}) >> 1))
    else $error("halving byte subtract lane 0 wrong");

  AST_HSUB8_LANE3: assert property (
    taken && op_code == simd_pkg::OP_HALVING_SUB_BYTES |=>
      simd_pkg::byte_of(result_r, 3) ==
      simd_pkg::byte_t'(({1'b0, simd_pkg::byte_of($past(first_source), 3)} -
                          {1'b0, simd_pkg::byte_of($past(second_source), 3)}) >> 1))
    else $error("halving byte subtract lane 3 wrong");

  AST_SEL_LANES: assert property (
    taken && op_code == simd_pkg::OP_SELECT_BYTES |=>
      simd_pkg::byte_of(result_r, 1) == ($past(per_byte_compare_flags[1]) ?
        simd_pkg::byte_of($past(first_source), 1) :
        simd_pkg::byte_of($past(second_source), 1)))
    else $error("select lane 1 from wrong source");

  AST_SEL_ALL_FLAGS: assert property (
    taken && op_code == simd_pkg::OP_SELECT_BYTES &&
    per_byte_compare_flags == 4'hF |=> result_r == $past(first_source))
    else $error("select with all flags set must copy first source");

  AST_SEL_NO_FLAGS: assert property (
    taken && op_code == simd_pkg::OP_SELECT_BYTES &&
    per_byte_compare_flags == 4'h0 |=> result_r == $past(second_source))
    else $error("select with no flags set must copy second source");

  AST_SAD: assert property (
    taken && op_code == simd_pkg::OP_BYTE_ABS_DIFF_SUM &&
    first_source == second_source |=> result_r == simd_pkg::WORD_RST)
    else $error("sum of differences of equal words not zero");

  AST_SAD_ACC: assert property (
    taken && op_code == simd_pkg::OP_BYTE_ABS_DIFF_SUM_ACC |=>
      simd_pkg::word_t'(result_r - $past(accumulator_source)) ==
      simd_pkg::word_t'(simd_pkg::abs_diff8(simd_pkg::byte_of($past(first_source), 0),
                                            simd_pkg::byte_of($past(second_source), 0)) +
                        simd_pkg::abs_diff8(simd_pkg::byte_of($past(first_source), 1),
                                            simd_pkg::byte_of($past(second_source), 1)) +
                        simd_pkg::abs_diff8(simd_pkg::byte_of($past(first_source), 2),
                                            simd_pkg::byte_of($past(second_source), 2)) +
                        simd_pkg::abs_diff8(simd_pkg::byte_of($past(first_source), 3),
                                            simd_pkg::byte_of($past(second_source), 3))))
    else $error("accumulating sum of differences wrong");

  AST_SUB16: assert property (
    taken && op_code == simd_pkg::OP_SUB_HALFWORDS |=>
      simd_pkg::half_t'(simd_pkg::hi_half(result_r) + simd_pkg::hi_half($past(second_source)))
      == simd_pkg::hi_half($past(first_source)))
    else $error("plain halfword subtract wrong");

  AST_SUB8: assert property (
    taken && op_code == simd_pkg::OP_SUB_BYTES |=>
      simd_pkg::byte_t'(simd_pkg::byte_of(result_r, 2) +
                        simd_pkg::byte_of($past(second_source), 2))
      == simd_pkg::byte_of($past(first_source), 2))
    else $error("plain byte subtract wrong");

  AST_DEST_DEFAULT: assert property (
    taken |=> result_dest_r == ($past(dest_given) ? $past(dest_index) : $past(first_index)))
    else $error("destination index wrong");

  AST_FAULT_PC: assert property (
    taken && op_code != simd_pkg::OP_SELECT_BYTES &&
    first_index == simd_pkg::PROGRAM_COUNTER_IDX |=> reg_fault_r)
    else $error("program counter operand not reported");

  AST_GUARD_BORROW: assert property (
    taken && op_code == simd_pkg::OP_HALVING_SUB_HALFWORDS &&
    simd_pkg::lo_half(first_source) < simd_pkg::lo_half(second_source) |=>
      result_r[simd_pkg::HALF_W-1])
    else $error("borrow lost before halving shift");

endmodule

/* tb_top.sv */
/*
  self-checking bench for the packed unsigned lane unit: corner operands,
  every op code and flag pattern, reserved indices, then seeded random ops.
  assumes the register file model supplies the operands.
*/
`timescale 1ns/10ps
module tb_top;
  logic                    clk, rst_n, op_valid, dest_given, ld_en;
  simd_pkg::op_e           op_code;
  simd_pkg::word_t         first_source, second_source, accumulator_source, ld_val;
  simd_pkg::idx_t          first_index, second_index, acc_index, dest_index, ld_idx;
  simd_pkg::flags_t        per_byte_compare_flags;
  simd_pkg::word_t         result_r;
  simd_pkg::idx_t          result_dest_r;
  logic                    result_valid_r, flags_write_r, reg_fault_r;
  int                      errors, checked;
  simd_pkg::word_t         sh [16];
  logic                    pend;
  simd_pkg::idx_t          pidx;
  simd_pkg::word_t         pval, last;

  simd_unsigned_halving_sad_unit simd_unsigned_halving_sad_unit_inst (
    .clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
    .first_source(first_source), .second_source(second_source),
    .accumulator_source(accumulator_source), .first_index(first_index),
    .second_index(second_index), .dest_index(dest_index), .dest_given(dest_given),
    .per_byte_compare_flags(per_byte_compare_flags), .result_r(result_r),
    .result_dest_r(result_dest_r), .result_valid_r(result_valid_r),
    .flags_write_r(flags_write_r), .reg_fault_r(reg_fault_r));

  regfile_model regfile_model_inst (
    .clk(clk), .rd_a_idx(first_index), .rd_b_idx(second_index), .rd_c_idx(acc_index),
    .rd_a(first_source), .rd_b(second_source), .rd_c(accumulator_source),
    .wb_valid(result_valid_r), .wb_idx(result_dest_r), .wb_data(result_r),
    .ld_en(ld_en), .ld_idx(ld_idx), .ld_val(ld_val));

  always #4 clk = ~clk;

  // ------------------------------------------------------------
  // expectation and checking
  // ------------------------------------------------------------
  function automatic simd_pkg::word_t exp_res(input logic [3:0] op, input simd_pkg::word_t a,
                                              input simd_pkg::word_t b, input simd_pkg::word_t c,
                                              input simd_pkg::flags_t f);
    logic [16:0]     h1, h0;
    logic [8:0]      d;
    simd_pkg::word_t r;
    r = 32'h0000_0000;
    h1 = {1'b0, a[31:16]} - b[31:16];
    h0 = {1'b0, a[15:0]} - b[15:0];
    if (op == 4'h0) begin
      h1 = {1'b0, a[31:16]} + b[15:0];
      h0 = {1'b0, a[15:0]} - b[31:16];
    end else if (op == 4'h1) begin
      h1 = {1'b0, a[31:16]} - b[15:0];
      h0 = {1'b0, a[15:0]} + b[31:16];
    end
    if (op <= 4'h2) r = {h1[16:1], h0[16:1]};
    if (op == 4'h6) r = {h1[15:0], h0[15:0]};
    for (int i = 0; i < 4; i++) begin
      d = {1'b0, a[8*i +: 8]} - b[8*i +: 8];
      if (op == 4'h3) r[8*i +: 8] = d[8:1];
      if (op == 4'h7) r[8*i +: 8] = d[7:0];
      // the inner cast keeps the negation at byte width before it is widened
      if (op == 4'h4 || op == 4'h5) r = r + (d[8] ? 32'(simd_pkg::byte_t'(~d[7:0] + 8'h01)) :
                                                    32'(d[7:0]));
      if (op == 4'h8) r[8*i +: 8] = f[i] ? a[8*i +: 8] : b[8*i +: 8];
    end
    if (op == 4'h5) r = r + c;
    return r;
  endfunction

  function automatic simd_pkg::idx_t pick();
    simd_pkg::idx_t v;
    v = 4'($urandom_range(0, 14));
    // stack pointer and program counter indices are never named
    if (v == 4'hD) v = 4'hC;
    return v;
  endfunction

  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic commit();
    if (pend) sh[pidx] = pval;
    pend = 1'b0;
  endtask

  task automatic load(input simd_pkg::idx_t i, input simd_pkg::word_t v);
    ld_en  <= 1'b1;
    ld_idx <= i;
    ld_val <= v;
    sh[i] = v;
    @(negedge clk);
  endtask

  task automatic idle();
    commit();
    op_valid <= 1'b0;
    ld_en    <= 1'b0;
    @(negedge clk);
    check("valid_idle", 32'(result_valid_r), 32'h0000_0000);
    check("result_hold", result_r, last);
  endtask

  // drives one request; the result is checked one cycle later
  task automatic do_op(input logic [3:0] op, input simd_pkg::idx_t a, input simd_pkg::idx_t b,
                       input simd_pkg::idx_t c, input simd_pkg::idx_t d, input logic g,
                       input simd_pkg::flags_t f);
    simd_pkg::word_t e;
    simd_pkg::idx_t  dst;
    logic            ef;
    e   = exp_res(op, sh[a], sh[b], sh[c], f);
    dst = g ? d : a;
    ef  = (op != 4'h8) && (a inside {4'hD, 4'hF} || b inside {4'hD, 4'hF} ||
                           dst inside {4'hD, 4'hF});
    commit();
    op_valid   <= 1'b1;
    ld_en      <= 1'b0;
    op_code    <= simd_pkg::op_e'(op);
    first_index <= a;
    second_index <= b;
    acc_index  <= c;
    dest_index <= d;
    dest_given <= g;
    per_byte_compare_flags <= f;
    @(negedge clk);
    check("valid", 32'(result_valid_r), 32'h0000_0001);
    case (op)
      4'h0: check("swap_add", result_r, e);
      4'h1: check("swap_sub", result_r, e);
      4'h2: check("half_sub_h", result_r, e);
      4'h3: check("half_sub_b", result_r, e);
      4'h4: check("sad", result_r, e);
      4'h5: check("sad_acc", result_r, e);
      4'h6: check("sub_h", result_r, e);
      4'h7: check("sub_b", result_r, e);
      4'h8: check("select", result_r, e);
      default: check("unknown_op", result_r, e);
    endcase
    check("dest", 32'(result_dest_r), 32'(dst));
    check("fault", 32'(reg_fault_r), 32'(ef));
    check("flags_write", 32'(flags_write_r), 32'h0000_0000);
    pend = 1'b1;
    pidx = dst;
    pval = e;
    last = e;
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0; rst_n = 1'b0; op_valid = 1'b0; dest_given = 1'b0; ld_en = 1'b0;
    op_code = simd_pkg::OP_HALVING_ADD_SUB_SWAP; ld_val = 32'h0000_0000;
    first_index = 4'h0; second_index = 4'h0; acc_index = 4'h0; dest_index = 4'h0;
    ld_idx = 4'h0; per_byte_compare_flags = 4'h0;
    errors = 0; checked = 0; pend = 1'b0; pidx = 4'h0; pval = 32'h0000_0000;
    last = 32'h0000_0000;
    void'($urandom(68037));
    repeat (8) @(negedge clk);
    check("valid_reset", 32'(result_valid_r), 32'h0000_0000);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    for (int i = 0; i < 16; i++) load(4'(i), $urandom());
    load(4'h1, 32'h0000_0000);
    load(4'h2, 32'hFFFF_FFFF);
    load(4'h3, 32'h8000_7FFF);
    load(4'h4, 32'h0001_FFFE);
    load(4'hA, 32'h8001_8001);
    // equal addends with a carry out, and equal words into the difference sum
    do_op(4'h0, 4'hA, 4'hA, 4'h0, 4'hC, 1'b1, 4'h0);
    do_op(4'h4, 4'hA, 4'hA, 4'h0, 4'hC, 1'b1, 4'h0);
    // every code on borrow and carry corners, back to back
    for (int op = 0; op < 16; op++) begin
      for (int p = 0; p < 3; p++) do_op(4'(op), 4'(1 + p), 4'(2 + p), 4'h2, 4'hC, 1'b1, 4'hA);
    end
    idle();
    for (int f = 0; f < 16; f++) do_op(4'h8, 4'h5, 4'h6, 4'h0, 4'hB, 1'b1, 4'(f));
    // two-register form writes over the first source
    do_op(4'h2, 4'h7, 4'h8, 4'h0, 4'h0, 1'b0, 4'h0);
    idle();
    do_op(4'h2, 4'h7, 4'h8, 4'h0, 4'h0, 1'b0, 4'h0);
    // reserved indices still execute and report a fault, except under select, which reports none
    do_op(4'h0, 4'hD, 4'h1, 4'h0, 4'h5, 1'b1, 4'h0);
    do_op(4'h1, 4'h1, 4'hF, 4'h0, 4'h5, 1'b1, 4'h0);
    do_op(4'h2, 4'h1, 4'h2, 4'h0, 4'hF, 1'b1, 4'h0);
    do_op(4'h8, 4'hD, 4'hF, 4'h0, 4'hD, 1'b1, 4'h3);
    do_op(4'h6, 4'hF, 4'h1, 4'h0, 4'h5, 1'b1, 4'h0);
    idle();
    for (int n = 0; n < 400; n++) begin
      if ($urandom_range(0, 19) == 0) begin
        idle();
        load(pick(), $urandom());
      end
      do_op(4'($urandom_range(0, 8)), pick(), pick(), pick(), pick(),
            1'($urandom_range(0, 1)), 4'($urandom_range(0, 15)));
    end
    idle();
    // second reset in mid-run clears the outputs
    rst_n = 1'b0;
    @(negedge clk);
    check("result_reset", result_r, 32'h0000_0000);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    last = 32'h0000_0000;
    do_op(4'h5, 4'h3, 4'h4, 4'h2, 4'h9, 1'b1, 4'h0);
    idle();
    finish_test();
  end

  initial begin
    #(8 * 20000);
    errors++;
    finish_test();
  end
endmodule
